// ===== logic/iois_pkg.sv
// Shared constants, field layout, states and carrier types of the I/O instruction sequencer.
package iois_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned UNIT_W = 6;
  localparam int unsigned NUNITS = 64;
  localparam int unsigned RADDR_W = 3;

  // ---------------------------------------------------------------
  // First instruction word layout (word bit 0 is the MSB, bit k is word[15-k])
  // ---------------------------------------------------------------
  localparam int unsigned OP_HI = 15;
  localparam int unsigned OP_LO = 12;
  localparam int unsigned MERGE_BIT = 11;
  localparam int unsigned IND_BIT = 10;
  localparam int unsigned MAP_BIT = 9;
  localparam int unsigned FN_HI = 8;
  localparam int unsigned FN_LO = 7;
  localparam int unsigned WAIT_BIT = 6;
  localparam int unsigned UNIT_HI = 5;
  localparam int unsigned UNIT_LO = 0;
  localparam logic [3:0] OP_CMD_TEST = 4'hb;
  localparam logic [3:0] OP_ACC_MEM = 4'hf;
  localparam logic [1:0] FN_CMD = 2'h0;
  localparam logic [1:0] FN_TEST = 2'h1;
  localparam logic [1:0] FN_AOP = 2'h0;

  // ---------------------------------------------------------------
  // Second word in indirect format
  // ---------------------------------------------------------------
  localparam int unsigned W2_IND_BIT = 15;
  localparam int unsigned W2_IDX_BIT = 14;
  localparam int unsigned W2_ADDR_HI = 13;
  localparam int unsigned PC_MSB = 14;

  // ---------------------------------------------------------------
  // Timing: one machine cycle spans two clocks of 40 ns
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned MCYCLE_NS = 80;
  localparam int unsigned MCYCLE_CLKS = (MCYCLE_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam logic [RADDR_W-1:0] REG_CTRL = 3'h0;
  localparam logic [RADDR_W-1:0] REG_PC = 3'h1;
  localparam logic [RADDR_W-1:0] REG_STATUS = 3'h2;
  localparam logic [RADDR_W-1:0] REG_IR = 3'h3;
  localparam logic [RADDR_W-1:0] REG_OPND = 3'h4;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CLR_ILL = 1;
  localparam logic [ADDR_W-1:0] PC_RST = 15'h0000;
  localparam logic [ADDR_W-1:0] PC_STEP1 = 15'h0001;
  localparam logic [ADDR_W-1:0] PC_STEP2 = 15'h0002;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FETCH = 6'h02,
    ST_DECODE = 6'h04,
    ST_ADDR = 6'h08,
    ST_READY = 6'h10,
    ST_XFER = 6'h20
  } iois_state_t;

  typedef struct packed {
    logic [UNIT_W-1:0] unit;
    logic connected;
    logic cmd_stb;
    logic out_stb;
    logic in_stb;
    logic test_stb;
    logic [WORD_W-1:0] data;
  } iois_io_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } iois_mem_t;

  typedef struct packed {
    logic load;
    logic merge;
    logic [WORD_W-1:0] data;
  } iois_acc_t;

endpackage

// ===== logic/iois_cycle_div.sv
// Machine cycle divider: one-cycle enable pulse every MCYCLE_CLKS clocks.
`timescale 1ns/1ns
module iois_cycle_div
  import iois_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  output logic tick // One-clock pulse per machine cycle.
);

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  localparam logic [7:0] LAST = 8'(MCYCLE_CLKS - 1);
  logic [7:0] cnt;

  // Free-running count; the pulse marks the last clock of each machine cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
    end else if (cnt == LAST) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  assign tick = (cnt == LAST);

endmodule

// ===== logic/iois_unit_dec.sv
// Unit number decoder: one select line per peripheral controller.
`timescale 1ns/1ns
module iois_unit_dec
  import iois_pkg::*;
(
  input wire logic [UNIT_W-1:0] unit, // Unit number of the current instruction.
  input wire logic enable, // Peripheral attached to the bus.
  output logic [NUNITS-1:0] sel // One-hot select, all low when detached.
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // A loop keeps the decoder small; only the addressed line may rise.
  always_comb begin
    sel = '0;
    for (int i = 0; i < NUNITS; i++) begin
      sel[i] = enable && (unit == UNIT_W'(i));
    end
  end

endmodule

// ===== logic/iois_top.sv
// I/O instruction sequencer: fetch, decode and execute of programmed I/O instructions.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
module iois_top
  import iois_pkg::*;
(
  input wire logic clk, // System clock, 25 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [RADDR_W-1:0] reg_addr, // Register address.
  input wire logic [WORD_W-1:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Register write strobe.
  input wire logic reg_rd, // Register read strobe.
  output logic [WORD_W-1:0] reg_rdata, // Read data, valid the cycle after reg_rd.
  output iois_mem_t mem, // Memory request.
  input wire logic [WORD_W-1:0] mem_rdata, // Memory read data.
  input wire logic [WORD_W-1:0] acc_in, // A-accumulator contents.
  input wire logic [WORD_W-1:0] idx_in, // Index register contents.
  output iois_acc_t acc, // Accumulator load request.
  output iois_io_t io, // I/O bus outputs.
  output logic [NUNITS-1:0] io_sel, // Peripheral selects.
  input wire logic [WORD_W-1:0] io_data_in, // Word from the peripheral.
  input wire logic io_ready, // Peripheral Ready.
  input wire logic io_test_ret // Peripheral Test Return.
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  iois_state_t state;
  iois_state_t next_state;
  logic tick;
  logic [ADDR_W-1:0] pc;
  logic [WORD_W-1:0] ir;
  logic [WORD_W-1:0] opnd;
  logic [ADDR_W-1:0] opnd_addr;
  logic opnd_have;
  logic run;
  logic illegal;
  logic last_skip;
  logic [WORD_W-1:0] iw;
  logic [3:0] op;
  logic [1:0] fn;
  logic legal;
  logic two_word;
  logic is_test;
  logic is_cmd;
  logic is_input;
  logic is_accout;
  logic wait_f;
  logic [ADDR_W-1:0] ea;
  logic go_xfer;
  logic finish;
  logic [ADDR_W-1:0] pc_step;
  logic [WORD_W-1:0] status;

  iois_cycle_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // The decoder is gated by the connect flag so no unit sees a select between instructions.
  iois_unit_dec u_dec (
    .unit(io.unit),
    .enable(io.connected),
    .sel(io_sel)
  );

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  // In the decode cycle the word is taken straight from memory, later from the latch.
  always_comb begin
    iw = (state == ST_DECODE) ? mem_rdata : ir;
    op = iw[OP_HI:OP_LO];
    fn = iw[FN_HI:FN_LO];
    legal = (op == OP_ACC_MEM) || ((op == OP_CMD_TEST) && !fn[1]);
    two_word = (op == OP_CMD_TEST) || fn[1];
    is_test = (op == OP_CMD_TEST) && (fn == FN_TEST);
    is_cmd = (op == OP_CMD_TEST) && (fn == FN_CMD);
    is_input = (op == OP_ACC_MEM) && fn[0];
    is_accout = (op == OP_ACC_MEM) && (fn == FN_AOP);
    wait_f = iw[WAIT_BIT] && !is_test;
    // Operand address of an indirect-format word; map supplies the top address bit.
    ea = {ir[MAP_BIT] ? pc[PC_MSB] : 1'b0, mem_rdata[W2_ADDR_HI:0]}
      + (mem_rdata[W2_IDX_BIT] ? idx_in[ADDR_W-1:0] : PC_RST);
  end

  // Ready is ignored by the test instruction; the test word always goes out.
  assign go_xfer = tick && (state == ST_READY) && (is_test || io_ready);
  assign finish = tick && ((state == ST_XFER)
    || ((state == ST_READY) && !is_test && !io_ready && !wait_f));
  // A skip follows any skip-mode transfer other than a test, or a test whose return says ready or go.
  assign pc_step = ((state == ST_XFER) && !wait_f && (!is_test || io_test_ret))
    ? PC_STEP2 : PC_STEP1;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state; every step takes one machine cycle, so a command is four plus waiting and one per indirect level.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_state = ST_DECODE;
      end
      ST_DECODE: begin
        if (!legal) begin
          next_state = ST_IDLE;
        end else if (two_word && iw[IND_BIT]) begin
          next_state = ST_ADDR;
        end else begin
          next_state = ST_READY;
        end
      end
      ST_ADDR: begin
        if (!mem_rdata[W2_IND_BIT]) begin
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (is_test || io_ready) begin
          next_state = ST_XFER;
        end else if (!wait_f) begin
          next_state = run ? ST_FETCH : ST_IDLE;
        end
      end
      ST_XFER: begin
        next_state = run ? ST_FETCH : ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register advances on the machine cycle pulse only.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else if (tick) begin
      state <= next_state;
    end
  end

  // Program counter: held while waiting, stepped past word two, stepped at the end.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= PC_RST;
    end else if (reg_wr && (reg_addr == REG_PC) && (state == ST_IDLE)) begin
      pc <= reg_wdata[ADDR_W-1:0];
    end else if (tick && (state == ST_DECODE) && legal && two_word) begin
      pc <= pc + PC_STEP1;
    end else if (finish) begin
      pc <= pc + pc_step;
    end
  end

  // ---------------------------------------------------------------
  // Instruction and operand latches
  // ---------------------------------------------------------------
  // The operand is the word read just before the ready test, from word two or the end of
  // the chain; it is latched once so a long wait does not depend on memory holding it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ir <= 16'h0000;
      opnd <= 16'h0000;
      opnd_addr <= PC_RST;
      opnd_have <= 1'b0;
      last_skip <= 1'b0;
    end else if (tick) begin
      if (state == ST_DECODE) begin
        ir <= mem_rdata;
        opnd_addr <= pc + PC_STEP1;
        opnd_have <= 1'b0;
      end
      if ((state == ST_ADDR) && !mem_rdata[W2_IND_BIT]) begin
        opnd_addr <= ea;
      end
      if ((state == ST_READY) && two_word && !opnd_have) begin
        opnd <= mem_rdata;
        opnd_have <= 1'b1;
      end
      if (finish) begin
        last_skip <= (pc_step == PC_STEP2);
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory port
  // ---------------------------------------------------------------
  // Reads: word one, word two, each indirect level. Write: input word for memory input.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem <= '0;
    end else begin
      mem.rd <= 1'b0;
      mem.wr <= 1'b0;
      if (tick) begin
        case (state)
          ST_FETCH: begin
            mem.rd <= 1'b1;
            mem.addr <= pc;
          end
          ST_DECODE: begin
            if (legal && two_word) begin
              mem.rd <= 1'b1;
              mem.addr <= pc + PC_STEP1;
            end
          end
          ST_ADDR: begin
            mem.rd <= 1'b1;
            mem.addr <= ea;
          end
          ST_XFER: begin
            if (is_input && two_word) begin
              mem.wr <= 1'b1;
              mem.addr <= opnd_addr;
              mem.wdata <= io_data_in;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Accumulator input: word handed over at the end of the transfer cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= '0;
    end else begin
      acc.load <= tick && (state == ST_XFER) && is_input && !two_word;
      if (tick && (state == ST_XFER)) begin
        acc.merge <= ir[MERGE_BIT];
        acc.data <= io_data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // I/O bus
  // ---------------------------------------------------------------
  // Attach at decode, detach when the instruction ends; strobes mark the transfer cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io <= '0;
    end else begin
      io.cmd_stb <= go_xfer && is_cmd;
      io.test_stb <= go_xfer && is_test;
      io.out_stb <= go_xfer && !is_input && !is_cmd && !is_test;
      io.in_stb <= go_xfer && is_input;
      if (tick && (state == ST_DECODE) && legal) begin
        io.connected <= 1'b1;
        io.unit <= mem_rdata[UNIT_HI:UNIT_LO];
      end else if (finish) begin
        io.connected <= 1'b0;
      end
      if (go_xfer) begin
        io.data <= is_accout ? acc_in : (opnd_have ? opnd : mem_rdata);
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // A non-I/O opcode stops the run; the stop wins over a software write in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 1'b0;
      illegal <= 1'b0;
    end else begin
      if (tick && (state == ST_DECODE) && !legal) begin
        run <= 1'b0;
      end else if (reg_wr && (reg_addr == REG_CTRL)) begin
        run <= reg_wdata[CTRL_RUN];
      end
      if (tick && (state == ST_DECODE) && !legal) begin
        illegal <= 1'b1;
      end else if (reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_CLR_ILL]) begin
        illegal <= 1'b0;
      end
    end
  end

  assign status = {2'h0, 6'(state), 4'h0, (state == ST_READY), last_skip, illegal,
    io.connected};

  // Read data stands for exactly the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= {15'h0000, run};
        REG_PC: reg_rdata <= {1'b0, pc};
        REG_STATUS: reg_rdata <= status;
        REG_IR: reg_rdata <= ir;
        REG_OPND: reg_rdata <= opnd;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_sel_one_hot: assert property (io.connected |-> $onehot(io_sel))
    else $error("select is not one-hot while attached");
  a_bus_free_idle: assert property ((state == ST_FETCH) |-> !io.connected && io_sel == '0)
    else $error("bus held between instructions");
  a_wait_holds_pc: assert property (tick && state == ST_READY && wait_f && !io_ready
    |=> state == ST_READY && $stable(pc))
    else $error("wait mode did not hold");
  a_wait_done_step: assert property (tick && state == ST_XFER && wait_f
    |=> pc == $past(pc) + PC_STEP1 && !io.connected)
    else $error("wait transfer did not step by one");
  a_skip_ready_two: assert property (tick && state == ST_XFER && !wait_f && !is_test
    |=> pc == $past(pc) + PC_STEP2)
    else $error("skip transfer did not step by two");
  a_skip_not_ready: assert property (tick && state == ST_READY && !wait_f && !is_test
    && !io_ready |=> pc == $past(pc) + PC_STEP1 && !io.connected && !io.out_stb)
    else $error("not ready skip mishandled");
  a_two_word_step: assert property (tick && state == ST_DECODE && legal && two_word
    |=> pc == $past(pc) + PC_STEP1 ##0 mem.rd && mem.addr == pc)
    else $error("second word not fetched");
  a_test_always: assert property (tick && state == ST_READY && is_test
    |=> io.test_stb ##1 !io.test_stb)
    else $error("test word not sent");
  a_test_skip: assert property (tick && state == ST_XFER && is_test && io_test_ret
    |=> pc == $past(pc) + PC_STEP2)
    else $error("test return did not skip");
  a_map_msb: assert property (tick && state == ST_ADDR && ir[MAP_BIT]
    && !mem_rdata[W2_IDX_BIT] |=> mem.addr[PC_MSB] == $past(pc[PC_MSB]))
    else $error("map bit not appended");

  c_wait_loop: cover property (state == ST_READY && wait_f && !io_ready && tick
    ##[1:20] go_xfer);
  c_skip_miss: cover property (tick && state == ST_READY && !wait_f && !io_ready && !is_test);
  c_test_skip: cover property (tick && state == ST_XFER && is_test && io_test_ret);
  c_indirect: cover property (tick && state == ST_ADDR && mem_rdata[W2_IND_BIT]);

endmodule

// ===== dv/iois_periph.sv
// Behavioural peripheral controller model on the parallel I/O bus.
`timescale 1ns/1ns
module iois_periph
  import iois_pkg::*;
#(
  parameter int unsigned UNIT = 5 // Unit number this controller answers to.
)
(
  input wire logic clk, // System clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic [NUNITS-1:0] sel, // Selects from the host.
  input iois_io_t io, // Host bus outputs.
  input wire logic [7:0] delay, // Clocks attached before Ready may rise.
  input wire logic able, // Controller can start new work.
  input wire logic ret, // Test return level to report.
  input wire logic [WORD_W-1:0] word, // Word offered for input.
  output logic ready, // Ready line.
  output logic test_ret, // Test return line.
  output logic [WORD_W-1:0] data_in // Word to the host.
);
  logic [7:0] cnt;
  logic [1:0] irq_en;
  logic on;

  assign on = sel[UNIT];

  // Counts clocks attached so a slow controller can be played.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 8'h00;
    end else if (!on) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end

  // Ready only when new work can start at once; released test return and data lines show the inverse.
  assign ready = on && able && (cnt >= delay);
  assign test_ret = on ? ret : ~ret;
  assign data_in = on ? word : ~word;

  // Each command bit acts alone; bits 2 and 3 enable group 1 levels 1 and 2.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en <= 2'h0;
    end else if (on && io.cmd_stb) begin
      irq_en <= {io.data[12], io.data[13]};
    end
  end
endmodule

// ===== dv/io_instruction_sequencer_bench.sv
// Self-checking bench for the I/O instruction sequencer.
`timescale 1ns/1ns
module io_instruction_sequencer_bench;
  import iois_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [RADDR_W-1:0] reg_addr = 3'h0;
  logic [WORD_W-1:0] reg_wdata = 16'h0000, reg_rdata, mem_rdata = 16'h0000;
  logic [WORD_W-1:0] acc_in = 16'h1234, idx_in = 16'h0002, pword = 16'h00a5;
  logic [WORD_W-1:0] io_data_in, sdata, adata, mem_arr [0:32767];
  logic reg_wr = 1'b0, reg_rd = 1'b0, io_ready, io_test_ret, able = 1'b1, ret = 1'b0, amerge;
  logic [7:0] delay = 8'h00;
  logic [NUNITS-1:0] io_sel, ssel;
  iois_mem_t mem;
  iois_acc_t acc;
  iois_io_t io;
  int errors = 0, samples_checked = 0, cyc = 0, nstb = 0, gap;
  int fq[$], tq[$];

  iois_top DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem(mem), .mem_rdata(mem_rdata),
    .acc_in(acc_in), .idx_in(idx_in), .acc(acc), .io(io), .io_sel(io_sel),
    .io_data_in(io_data_in), .io_ready(io_ready), .io_test_ret(io_test_ret));
  iois_periph #(.UNIT(5)) PERIPH (.clk(clk), .arst_n(arst_n), .sel(io_sel), .io(io),
    .delay(delay), .able(able), .ret(ret), .word(pword), .ready(io_ready),
    .test_ret(io_test_ret), .data_in(io_data_in));

  initial begin
    foreach (mem_arr[i]) mem_arr[i] = 16'h0000;
    forever #20 clk = ~clk;
  end

  // Memory model and bus observer; every read address is queued with its clock.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem.rd) begin
      mem_rdata <= mem_arr[mem.addr];
      fq.push_back(int'(mem.addr));
      tq.push_back(cyc);
    end
    if (mem.wr) mem_arr[mem.addr] <= mem.wdata;
    if (io.cmd_stb || io.out_stb || io.in_stb || io.test_stb) begin
      sdata <= io.data;
      ssel <= io_sel;
      nstb <= nstb + 1;
    end
    if (acc.load) {amerge, adata} <= {acc.merge, acc.data};
  end

  task automatic finish_test();
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [RADDR_W-1:0] a, input logic [WORD_W-1:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, so it is taken 1 ns in.
  task automatic rd(input logic [RADDR_W-1:0] a, output logic [WORD_W-1:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask

  function automatic logic [WORD_W-1:0] ins(input logic [3:0] op, input logic [1:0] fn,
      input logic i, input logic m, input logic w);
    return {op, 1'b0, i, m, fn, w, 6'h05};
  endfunction

  // Runs one instruction; the zeroed word at the next address stops the run.
  task automatic exec(input logic [ADDR_W-1:0] p, input logic [WORD_W-1:0] w1,
      input logic [WORD_W-1:0] w2, input logic [ADDR_W-1:0] npc, input int nst);
    logic [WORD_W-1:0] st;
    int n0;
    n0 = nstb;
    st = 16'h0000;
    fq.delete();
    tq.delete();
    mem_arr[p] = w1;
    mem_arr[p + 15'h0001] = w2;
    wr(REG_PC, {1'b0, p});
    wr(REG_CTRL, 16'h0001);
    for (int i = 0; i < 200 && st[1] !== 1'b1; i++) rd(REG_STATUS, st);
    if (st[1] !== 1'b1) begin
      errors++;
      $display("[ERR] %0t sequencer did not stop", $time);
      finish_test();
    end
    wr(REG_CTRL, 16'h0002);
    gap = tq[$] - tq[0];
    chk(64'(fq[$]), 64'(npc));
    chk(64'(nstb - n0), 64'(nst));
    if (nst > 0) chk(ssel, 64'h20);
    chk(io_sel, 64'h0);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [WORD_W-1:0] d;
    rd(REG_PC, d);
    chk(d, 64'h0);
    rd(REG_STATUS, d);
    chk(d, 64'h0100);
    rd(3'h7, d);
    chk(d, 64'h0);
  endtask

  task automatic t_command();
    logic [WORD_W-1:0] d;
    exec(15'h0010, ins(OP_CMD_TEST, FN_CMD, 1'b0, 1'b0, 1'b0), 16'h2001, 15'h0013, 1);
    chk(gap, 8);
    chk(sdata, 16'h2001);
    chk(PERIPH.irq_en, 64'h1);
    rd(REG_OPND, d);
    chk(d, 16'h2001);
    delay <= 8'h09;
    exec(15'h0020, ins(OP_CMD_TEST, FN_CMD, 1'b0, 1'b0, 1'b1), 16'h0c0c, 15'h0022, 1);
    chk(64'(gap > 8), 64'h1);
    delay <= 8'h00;
    able <= 1'b0;
    exec(15'h0030, ins(OP_CMD_TEST, FN_CMD, 1'b0, 1'b0, 1'b0), 16'h0c0c, 15'h0032, 0);
    able <= 1'b1;
  endtask

  // Address, chain, index and map forms in both execution modes.
  task automatic t_address();
    logic [ADDR_W-1:0] p, ea;
    for (int k = 0; k < 4; k++) begin
      p = (k > 1 ? 15'h4000 : 15'h0000) | 15'(8'h40 + 4 * k);
      ea = k == 1 ? 15'h0100 : ((k > 1 ? 15'h4000 : 15'h0000) | 15'h0102);
      mem_arr[15'h0300] = 16'h0100;
      mem_arr[ea] = 16'hd000 + 16'(k);
      exec(p, ins(OP_CMD_TEST, FN_CMD, 1'b1, k > 1, k[0]),
        k == 1 ? 16'h8300 : (k == 3 ? 16'h0102 : 16'h4100),
        p + (k[0] ? 15'h0002 : 15'h0003), 1);
      chk(sdata, 16'hd000 + 16'(k));
      chk(PERIPH.irq_en, 64'h2);
    end
  endtask

  task automatic t_test();
    able <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      ret <= r[0];
      exec(15'(8'h50 + 4 * r), ins(OP_CMD_TEST, FN_TEST, 1'b0, 1'b0, 1'b0), 16'h0f0f,
        15'(8'h52 + 5 * r), 1);
      chk(sdata, 16'h0f0f);
    end
    able <= 1'b1;
  endtask

  task automatic t_transfer();
    exec(15'h0060, ins(OP_ACC_MEM, FN_AOP, 1'b0, 1'b0, 1'b0), 16'h0000, 15'h0062, 1);
    chk(sdata, acc_in);
    exec(15'h0070, ins(OP_ACC_MEM, 2'h1, 1'b0, 1'b0, 1'b0) | 16'h0800, 16'h0000, 15'h0072,
      1);
    chk(adata, pword);
    chk(amerge, 1'b1);
    exec(15'h0080, ins(OP_ACC_MEM, 2'h3, 1'b0, 1'b0, 1'b0), 16'h1111, 15'h0083, 1);
    chk(mem_arr[15'h0081], pword);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_command();
    t_address();
    t_test();
    t_transfer();
    finish_test();
  end
endmodule
